// >>> rtl/clip_irq_ctrl.v
// clock-loss detection, shutdown flag and interrupt pin control
`timescale 1ns/1ps
`include "clip_map.vh"
module clip_irq_ctrl #(
  parameter CNT_W     = 32,
  parameter US_CYCLES = `CLIP_CLK_MHZ,
  parameter PULSE_CYC = `CLIP_PULSE_US * `CLIP_CLK_MHZ,
  parameter PERIOD_CYC = `CLIP_PERIOD_US * `CLIP_CLK_MHZ
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // register port
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrEn,
  input  wire       regRdEn,
  output reg  [7:0] regRdData,
  // watched clocks, sampled as synchronous inputs, and the divided pdm clock routed to the pin
  input  wire       asiClk,
  input  wire       pdmClk,
  input  wire       dacModClk,
  input  wire       adcModClk,
  input  wire       pllClk,
  input  wire       dividedPdmInputClock,
  // amplifier control
  output wire       ampShutdown,
  // interrupt pin
  output reg        intPinOut,
  output reg        intPinOe,
  output reg        intPinPullUp,
  output reg        intPinPullDown
);

  // ****************************************************************
  // registers
  // ****************************************************************
  reg        clkErr_q;
  reg [7:0]  detectSetup_q;
  reg [7:0]  timeouts_q;
  reg [7:0]  pinSetup_q;
  reg [7:0]  indSetup_q;
  reg [7:0]  irqMask_q;
  reg        detClk1_q;
  reg        detClk2_q;
  reg        pending_q;
  reg        readFirst_q;
  reg        readSecond_q;
  reg        shot_q;
  reg [CNT_W-1:0] indCnt_q;

  wire [2:0] detectorOneTimeout = timeouts_q[`CLIP_FLD_T1_HI:`CLIP_FLD_T1_LO];
  wire [2:0] detectorTwoTimeout = timeouts_q[`CLIP_FLD_T2_HI:`CLIP_FLD_T2_LO];
  wire       detectorOneSource  = detectSetup_q[`CLIP_FLD_E1_SRC];
  wire       detectorOneEnable  = detectSetup_q[`CLIP_FLD_E1_EN];
  wire       detectorTwoEnable  = detectSetup_q[`CLIP_FLD_E2_EN];
  wire [1:0] detectorTwoSource  = detectSetup_q[`CLIP_FLD_E2_SRC_HI:`CLIP_FLD_E2_SRC_LO];
  wire [2:0] pinFunction        = pinSetup_q[`CLIP_FLD_FUNC_HI:`CLIP_FLD_FUNC_LO];
  wire [2:0] pinDrive           = pinSetup_q[`CLIP_FLD_DRIVE_HI:`CLIP_FLD_DRIVE_LO];
  wire       intPinGeneralLevel = pinSetup_q[`CLIP_FLD_GPO_VAL];
  wire [1:0] indicationStyle    = indSetup_q[`CLIP_FLD_IND_HI:`CLIP_FLD_IND_LO];

  // ****************************************************************
  // timeout decode
  // ****************************************************************
  // absence time of a code, in core cycles; shared by both detectors
  function [CNT_W-1:0] timeoutCycles;
    input [2:0] code;
    reg   [31:0] us;
    begin
      case (code)
        3'h0:    us = `CLIP_TO0_US;
        3'h1:    us = `CLIP_TO1_US;
        3'h2:    us = `CLIP_TO2_US;
        3'h3:    us = `CLIP_TO3_US;
        3'h4:    us = `CLIP_TO4_US;
        3'h5:    us = `CLIP_TO5_US;
        3'h6:    us = `CLIP_TO6_US;
        default: us = `CLIP_TO7_US;
      endcase
      timeoutCycles = us[CNT_W-1:0] * US_CYCLES[CNT_W-1:0];
    end
  endfunction

  // ****************************************************************
  // detectors
  // ****************************************************************
  reg  watchTwo;
  wire watchOne = detectorOneSource ? pdmClk : asiClk;
  wire lossOne;
  wire lossTwo;

  // reserved source code watches nothing, so an enabled detector times out
  always @* begin
    case (detectorTwoSource)
      2'h0:    watchTwo = dacModClk;
      2'h1:    watchTwo = adcModClk;
      2'h2:    watchTwo = pllClk;
      default: watchTwo = 1'b0;
    endcase
  end

  clip_loss_timer #(.CNT_W(CNT_W)) uTimerOne (
    .clk     (clk),
    .rst_n   (rst_n),
    .enable  (detectorOneEnable),
    .watched (watchOne),
    .limit   (timeoutCycles(detectorOneTimeout)),
    .expired (lossOne)
  );

  clip_loss_timer #(.CNT_W(CNT_W)) uTimerTwo (
    .clk     (clk),
    .rst_n   (rst_n),
    .enable  (detectorTwoEnable),
    .watched (watchTwo),
    .limit   (timeoutCycles(detectorTwoTimeout)),
    .expired (lossTwo)
  );

  // the error bit shuts the amplifier down until the host clears it
  assign ampShutdown = clkErr_q;

  wire irqEvent = (lossOne & irqMask_q[`CLIP_FLD_MASK_CLK1]) |
                  (lossTwo & irqMask_q[`CLIP_FLD_MASK_CLK2]);
  wire rdFirst  = regRdEn && regAddr == `CLIP_OFS_DETECT_FIRST;
  wire rdSecond = regRdEn && regAddr == `CLIP_OFS_DETECT_SECOND;
  wire wr       = regWrEn;

  // ****************************************************************
  // register writes, sticky flags
  // ****************************************************************
  // hardware sets win over a clear in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkErr_q      <= 1'b0;
      detectSetup_q <= `CLIP_RST_DETECT_SETUP;
      timeouts_q    <= `CLIP_RST_TIMEOUTS;
      pinSetup_q    <= `CLIP_RST_PIN_SETUP;
      indSetup_q    <= `CLIP_RST_IND_SETUP;
      irqMask_q     <= `CLIP_RST_IRQ_MASK;
      detClk1_q     <= 1'b0;
      detClk2_q     <= 1'b0;
    end else begin
      if (wr && regAddr == `CLIP_OFS_DETECT_SETUP) detectSetup_q <= regWrData;
      if (wr && regAddr == `CLIP_OFS_TIMEOUTS)    timeouts_q <= regWrData;
      if (wr && regAddr == `CLIP_OFS_PIN_SETUP)   pinSetup_q <= regWrData;
      if (wr && regAddr == `CLIP_OFS_IND_SETUP)   indSetup_q <= regWrData;
      if (wr && regAddr == `CLIP_OFS_IRQ_MASK)    irqMask_q  <= regWrData;
      // write one to bit 0 clears the error
      if (lossOne || lossTwo) begin
        clkErr_q <= 1'b1;
      end else if (wr && regAddr == `CLIP_OFS_FAULT_STATUS && regWrData[`CLIP_FLD_CLK_ERR]) begin
        clkErr_q <= 1'b0;
      end
      // detect flags clear on read
      if (lossOne)      detClk1_q <= 1'b1;
      else if (rdFirst) detClk1_q <= 1'b0;
      if (lossTwo)      detClk2_q <= 1'b1;
      else if (rdFirst) detClk2_q <= 1'b0;
    end
  end

  // ****************************************************************
  // register reads
  // ****************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        `CLIP_OFS_FAULT_STATUS:  regRdData <= {7'h00, clkErr_q};
        `CLIP_OFS_DETECT_SETUP:  regRdData <= detectSetup_q;
        `CLIP_OFS_TIMEOUTS:      regRdData <= timeouts_q;
        `CLIP_OFS_PIN_SETUP:     regRdData <= pinSetup_q;
        `CLIP_OFS_IND_SETUP:     regRdData <= indSetup_q;
        `CLIP_OFS_IRQ_MASK:      regRdData <= irqMask_q;
        `CLIP_OFS_DETECT_FIRST:  regRdData <= {2'h0, detClk1_q, 2'h0, detClk2_q, 2'h0};
        default:                 regRdData <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // indication timing
  // ****************************************************************
  // pending lasts until both detect registers were read after the event;
  // the counter wraps each period so the pulse train keeps its phase
  wire lastCnt = indCnt_q == PERIOD_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_q    <= 1'b0;
      readFirst_q  <= 1'b0;
      readSecond_q <= 1'b0;
      shot_q       <= 1'b0;
      indCnt_q     <= {CNT_W{1'b0}};
    end else if (irqEvent) begin
      pending_q    <= 1'b1;
      readFirst_q  <= 1'b0;
      readSecond_q <= 1'b0;
      shot_q       <= 1'b1;
      indCnt_q     <= {CNT_W{1'b0}};
    end else begin
      if (rdFirst)  readFirst_q  <= 1'b1;
      if (rdSecond) readSecond_q <= 1'b1;
      if ((readFirst_q | rdFirst) && (readSecond_q | rdSecond)) begin
        pending_q <= 1'b0;
      end
      if (indCnt_q == PULSE_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1}) shot_q <= 1'b0;
      if (pending_q || shot_q) begin
        indCnt_q <= lastCnt ? {CNT_W{1'b0}} : indCnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
        indCnt_q <= {CNT_W{1'b0}};
      end
    end
  end

  reg irqLevel;
  always @* begin
    case (indicationStyle)
      `CLIP_IND_PULSE: irqLevel = shot_q;
      `CLIP_IND_TRAIN: irqLevel = pending_q && indCnt_q < PULSE_CYC[CNT_W-1:0];
      `CLIP_IND_LEVEL: irqLevel = pending_q;
      default:         irqLevel = 1'b0;
    endcase
  end

  // ****************************************************************
  // pin function and drive
  // ****************************************************************
  reg pinLevel;
  reg pinActive;
  always @* begin
    pinActive = 1'b1;
    case (pinFunction)
      `CLIP_FUNC_IRQ: pinLevel = irqLevel;
      `CLIP_FUNC_GPO: pinLevel = intPinGeneralLevel;
      `CLIP_FUNC_PDM: pinLevel = dividedPdmInputClock;
      default: begin
        pinLevel  = 1'b0; // off and reserved codes leave the buffers dead
        pinActive = 1'b0;
      end
    endcase
  end

  // registered so the pin never glitches on a field change
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intPinOut      <= 1'b0;
      intPinOe       <= 1'b0;
      intPinPullUp   <= 1'b0;
      intPinPullDown <= 1'b0;
    end else begin
      intPinPullUp   <= pinActive && pinDrive == `CLIP_DRV_LOW_PU;
      intPinPullDown <= pinActive && pinDrive == `CLIP_DRV_HIGH_PD;
      case (pinDrive)
        `CLIP_DRV_PUSH: begin
          intPinOut <= pinLevel;
          intPinOe  <= pinActive;
        end
        `CLIP_DRV_LOW, `CLIP_DRV_LOW_PU: begin
          intPinOut <= 1'b0;
          intPinOe  <= pinActive & ~pinLevel;
        end
        `CLIP_DRV_HIGH, `CLIP_DRV_HIGH_PD: begin
          intPinOut <= 1'b1;
          intPinOe  <= pinActive & pinLevel;
        end
        default: begin
          intPinOut <= 1'b0;
          intPinOe  <= 1'b0;
        end
      endcase
    end
  end

endmodule

// >>> common/clip_map.vh
// register map, field positions, reset values and timing figures of the clock-loss block
`ifndef CLIP_MAP_VH
`define CLIP_MAP_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define CLIP_ADDR_W            8
`define CLIP_OFS_FAULT_STATUS  8'h05
`define CLIP_OFS_DETECT_SETUP  8'h21
`define CLIP_OFS_TIMEOUTS      8'h22
`define CLIP_OFS_PIN_SETUP     8'h23
`define CLIP_OFS_IND_SETUP     8'h24
`define CLIP_OFS_IRQ_MASK      8'h25
`define CLIP_OFS_DETECT_FIRST  8'h26
`define CLIP_OFS_DETECT_SECOND 8'h27

// ****************************************************************
// reset values
// ****************************************************************
`define CLIP_RST_DETECT_SETUP  8'h03
`define CLIP_RST_TIMEOUTS      8'h3f
`define CLIP_RST_PIN_SETUP     8'h21
`define CLIP_RST_IND_SETUP     8'h00
`define CLIP_RST_IRQ_MASK      8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define CLIP_FLD_CLK_ERR       0
`define CLIP_FLD_E2_EN         0
`define CLIP_FLD_E1_EN         1
`define CLIP_FLD_E2_SRC_LO     2
`define CLIP_FLD_E2_SRC_HI     3
`define CLIP_FLD_E1_SRC        4
`define CLIP_FLD_T2_LO         0
`define CLIP_FLD_T2_HI         2
`define CLIP_FLD_T1_LO         3
`define CLIP_FLD_T1_HI         5
`define CLIP_FLD_FUNC_LO       0
`define CLIP_FLD_FUNC_HI       2
`define CLIP_FLD_GPO_VAL       4
`define CLIP_FLD_DRIVE_LO      5
`define CLIP_FLD_DRIVE_HI      7
`define CLIP_FLD_IND_LO        6
`define CLIP_FLD_IND_HI        7
`define CLIP_FLD_MASK_CLK1     2
`define CLIP_FLD_MASK_CLK2     5
`define CLIP_FLD_DET_CLK1      5
`define CLIP_FLD_DET_CLK2      2

// ****************************************************************
// field codes
// ****************************************************************
`define CLIP_FUNC_OFF          3'h0
`define CLIP_FUNC_IRQ          3'h1
`define CLIP_FUNC_GPO          3'h3
`define CLIP_FUNC_PDM          3'h4
`define CLIP_DRV_PUSH          3'h0
`define CLIP_DRV_LOW           3'h1
`define CLIP_DRV_HIGH          3'h2
`define CLIP_DRV_LOW_PU        3'h3
`define CLIP_DRV_HIGH_PD       3'h4
`define CLIP_IND_PULSE         2'h0
`define CLIP_IND_TRAIN         2'h1
`define CLIP_IND_LEVEL         2'h2

// ****************************************************************
// timing, in microseconds, and the clock rate
// ****************************************************************
`define CLIP_CLK_MHZ           250
`define CLIP_TO0_US            11000
`define CLIP_TO1_US            22000
`define CLIP_TO2_US            44000
`define CLIP_TO3_US            87000
`define CLIP_TO4_US            174000
`define CLIP_TO5_US            350000
`define CLIP_TO6_US            700000
`define CLIP_TO7_US            1200000
`define CLIP_PULSE_US          2000
`define CLIP_PERIOD_US         4000

`endif

// >>> rtl/clip_loss_timer.v
// missing-clock timeout counter for one detector
`timescale 1ns/1ps
module clip_loss_timer #(
  parameter CNT_W = 32
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // control
  input  wire             enable,
  input  wire             watched,
  input  wire [CNT_W-1:0] limit,
  // result
  output wire             expired
);

  reg             prev_q;
  reg             done_q;
  reg [CNT_W-1:0] count_q;
  wire            edgeSeen = watched ^ prev_q;

  // fire once when the count meets the limit, then park; a limit lowered below a
  // running count still fires on the next step instead of waiting for a wrap
  assign expired = enable & ~edgeSeen & ~done_q &
                   (count_q >= limit - {{(CNT_W-1){1'b0}}, 1'b1});

  // counter restarts on any edge of the watched clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q  <= 1'b0;
      done_q  <= 1'b0;
      count_q <= {CNT_W{1'b0}};
    end else begin
      prev_q <= watched;
      if (!enable || edgeSeen) begin
        count_q <= {CNT_W{1'b0}};
        done_q  <= 1'b0;
      end else begin
        if (expired) done_q <= 1'b1;
        if (count_q < limit) count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// >>> bench/clip_host_model.sv
// host-side view of the interrupt pin: resolves the wire level the host sees
`timescale 1ns/1ps
module clip_host_model (
  // pin from the device
  input  wire intPinOut,
  input  wire intPinOe,
  input  wire intPinPullUp,
  input  wire intPinPullDown,
  // level seen by the host
  output reg  pinLevel
);
  reg lastQ = 1'b0;

  // remember the last driven level
  always @(intPinOe or intPinOut) begin
    if (intPinOe)
      lastQ = intPinOut;
  end

  // a floating wire without a pull reads inverted, so a stale level never looks driven
  always @* begin
    if (intPinOe)
      pinLevel = intPinOut;
    else if (intPinPullUp)
      pinLevel = 1'b1;
    else if (intPinPullDown)
      pinLevel = 1'b0;
    else
      pinLevel = ~lastQ;
  end
endmodule

// >>> bench/clip_irq_checker.sv
// concurrent checks on the register port and interrupt pin of the clock-loss block
`timescale 1ns/1ps
module clip_irq_checker (
  // clock and reset
  input wire       clk,
  input wire       rst_n,
  // register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWrEn,
  input wire       regRdEn,
  input wire [7:0] regRdData,
  // outputs and pin
  input wire       dividedPdmInputClock,
  input wire       ampShutdown,
  input wire       intPinOut,
  input wire       intPinOe,
  input wire       intPinPullUp,
  input wire       intPinPullDown
);
  reg  [7:0] pinQ;
  reg  [7:0] toQ;
  wire [2:0] fn   = pinQ[2:0];
  wire [2:0] dr   = pinQ[7:5];
  wire       okFn = (fn == 3'h1) || (fn == 3'h3) || (fn == 3'h4);

  // shadow copies of the pin setup and timeouts registers, pins lag them by one cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinQ <= 8'h21;
      toQ  <= 8'h3f;
    end else if (regWrEn) begin
      if (regAddr == 8'h23)
        pinQ <= regWrData;
      if (regAddr == 8'h22)
        toQ <= regWrData;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_read_pin: assert property (regRdEn && !regWrEn && regAddr == 8'h23 |=>
    regRdData == $past(pinQ)) else $error("pin setup read back wrong");
  a_read_timeouts: assert property (regRdEn && !regWrEn && regAddr == 8'h22 |=>
    regRdData[5:0] == $past(toQ[5:0])) else $error("timeouts read back wrong");
  a_pin_off: assert property (!$past(okFn) |->
    !intPinOe && !intPinPullUp && !intPinPullDown) else $error("idle pin not released");
  a_gpo_level: assert property ($past(fn) == 3'h3 && $past(dr) == 3'h0 |->
    intPinOe && intPinOut == $past(pinQ[4])) else $error("general output level wrong");
  a_drive_low: assert property ($past(okFn) && $past(dr) == 3'h1 |->
    !intPinOut && !intPinPullUp && !intPinPullDown) else $error("low-only drive wrong");
  a_drive_high: assert property ($past(okFn) && $past(dr) == 3'h2 |->
    intPinOut && !intPinPullUp && !intPinPullDown) else $error("high-only drive wrong");
  a_pull_up: assert property ($past(okFn) && $past(dr) == 3'h3 |->
    !intPinOut && intPinPullUp && !intPinPullDown) else $error("pull-up style wrong");
  a_pull_down: assert property ($past(okFn) && $past(dr) == 3'h4 |->
    intPinOut && intPinPullDown && !intPinPullUp) else $error("pull-down style wrong");
  a_bad_drive: assert property ($past(dr) > 3'h4 |-> !intPinOe)
    else $error("reserved drive code drives pin");
  a_pdm_route: assert property ($past(fn) == 3'h4 && $past(dr) == 3'h0 &&
    $past(dividedPdmInputClock, 2) == $past(dividedPdmInputClock) |->
    intPinOe && intPinOut == $past(dividedPdmInputClock)) else $error("pdm clock not routed");
  a_error_holds: assert property (ampShutdown &&
    !(regWrEn && regAddr == 8'h05 && regWrData[0]) |=> ampShutdown)
    else $error("clock error dropped without clear");

  c_loss: cover property ($rose(ampShutdown));
  c_gpo_high: cover property ($past(fn) == 3'h3 && intPinOut);
  c_pull_up: cover property (intPinPullUp);
endmodule

bind clip_irq_ctrl clip_irq_checker u_chk (.clk, .rst_n, .regAddr, .regWrData, .regWrEn,
  .regRdEn, .regRdData, .dividedPdmInputClock, .ampShutdown, .intPinOut, .intPinOe,
  .intPinPullUp, .intPinPullDown);

// >>> bench/tb.sv
// self-checking bench for the clock-loss detector and interrupt pin control
`timescale 1ns/1ps
`define CHK(a, b) begin \
  checks = checks + 1; \
  if ((a) !== (b)) begin \
    errors = errors + 1; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); \
  end end
module tb;
  reg        clk       = 1'b0;
  reg        rst_n     = 1'b0;
  reg  [7:0] regAddr   = 8'h00;
  reg  [7:0] regWrData = 8'h00;
  reg        regWrEn   = 1'b0;
  reg        regRdEn   = 1'b0;
  reg        asiClk    = 1'b0;
  reg        asiRun    = 1'b0;
  reg        pdmDiv    = 1'b0;
  reg        pdmClk    = 1'b0;
  reg        pdmRun    = 1'b0;
  reg        dacModClk = 1'b0;
  wire [7:0] regRdData;
  wire       ampShutdown, intPinOut, intPinOe, intPinPullUp, intPinPullDown, pinLevel;
  integer    errors    = 0;
  integer    checks    = 0;
  integer    i;
  integer    n;
  reg  [7:0] d;

  // short timeouts: one cycle per microsecond, pulse 4 cycles in a period of 8
  clip_irq_ctrl #(.US_CYCLES(1), .PULSE_CYC(4), .PERIOD_CYC(8)) u_dut (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .asiClk(asiClk), .pdmClk(pdmClk), .dacModClk(dacModClk), .adcModClk(1'b0), .pllClk(1'b0),
    .dividedPdmInputClock(pdmDiv), .ampShutdown(ampShutdown), .intPinOut(intPinOut),
    .intPinOe(intPinOe), .intPinPullUp(intPinPullUp), .intPinPullDown(intPinPullDown));
  clip_host_model u_host (.intPinOut(intPinOut), .intPinOe(intPinOe),
    .intPinPullUp(intPinPullUp), .intPinPullDown(intPinPullDown), .pinLevel(pinLevel));

  // clock and the watched serial clock
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    if (asiRun)
      asiClk <= ~asiClk;
  end
  // the converter clock runs free; the pdm clock only while pdmRun is set
  always @(posedge clk) begin
    if (pdmRun)
      pdmClk <= ~pdmClk;
    dacModClk <= ~dacModClk;
  end

  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk);
      regAddr   <= a;
      regWrData <= v;
      regWrEn   <= 1'b1;
      @(posedge clk);
      regWrEn   <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk);
      regRdEn <= 1'b0;
      @(posedge clk);
      v = regRdData;
    end
  endtask
  // bounded wait for the shutdown, then the elapsed count must sit in its window
  task waitLoss(input integer lo, input integer hi);
    begin
      n = 0;
      while (ampShutdown !== 1'b1 && n < hi) begin
        @(posedge clk);
        n = n + 1;
      end
      `CHK(n >= lo && n < hi, 1'b1)
      if (n >= hi)
        finish_test;
    end
  endtask
  task highs(input integer exp);
    begin
      n = 0;
      repeat (16) begin
        @(posedge clk);
        n = n + pinLevel;
      end
      `CHK(n, exp)
    end
  endtask
  task finish_test;
    begin
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  function [3:0] expPin(input [2:0] dr, input v);
    case (dr)
      3'h0: expPin = {1'b1, v, 2'b00};
      3'h1: expPin = {~v, 3'b000};
      3'h2: expPin = {v, 1'b1, 2'b00};
      3'h3: expPin = {~v, 3'b010};
      default: expPin = {v, 3'b101};
    endcase
  endfunction

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, read-back and an unmapped place
    rd(8'h22, d); `CHK(d, 8'h3f)
    rd(8'h23, d); `CHK(d, 8'h21)
    rd(8'h24, d); `CHK(d, 8'h00)
    rd(8'h30, d); `CHK(d, 8'h00)
    wr(8'h22, 8'h2a); rd(8'h22, d); `CHK(d[5:0], 6'h2a)
    wr(8'h24, 8'hc0); rd(8'h24, d); `CHK(d, 8'hc0)
    $display("register test done");
    // every drive style with both general output levels
    for (i = 0; i < 10; i = i + 1) begin
      wr(8'h23, {i[3:1], i[0], 4'h3});
      repeat (2) @(posedge clk);
      `CHK({intPinOe, intPinOut, intPinPullUp, intPinPullDown}, expPin(i[3:1], i[0]))
    end
    wr(8'h23, 8'h00); repeat (2) @(posedge clk); `CHK(intPinOe, 1'b0)
    wr(8'h23, 8'h02); repeat (2) @(posedge clk); `CHK(intPinOe, 1'b0)
    wr(8'h23, 8'ha3); repeat (2) @(posedge clk); `CHK(intPinOe, 1'b0)
    wr(8'h23, 8'h04); pdmDiv <= 1'b1; repeat (3) @(posedge clk);
    `CHK({intPinOe, intPinOut}, 2'b11)
    pdmDiv <= 1'b0; repeat (3) @(posedge clk); `CHK({intPinOe, intPinOut}, 2'b10)
    $display("pin test done");
    // detector one on the serial clock, pulse-train indication
    wr(8'h23, 8'h01); wr(8'h25, 8'h24); wr(8'h24, 8'h40); wr(8'h22, 8'h00);
    asiRun <= 1'b1;
    wr(8'h21, 8'h02);
    repeat (12000) @(posedge clk);
    `CHK(ampShutdown, 1'b0)
    asiRun <= 1'b0;
    waitLoss(10995, 11006);
    repeat (4) @(posedge clk); highs(8);
    rd(8'h26, d); `CHK(d, 8'h20)
    highs(8);
    rd(8'h27, d); `CHK(d, 8'h00)
    repeat (4) @(posedge clk); highs(0);
    // host clears the error before powering up again
    wr(8'h21, 8'h00); wr(8'h05, 8'h01); repeat (2) @(posedge clk);
    `CHK(ampShutdown, 1'b0)
    $display("detector one test done");
    // detector two on a stopped source, second code, held indication
    wr(8'h24, 8'h80); wr(8'h22, 8'h01); wr(8'h21, 8'h09);
    waitLoss(21995, 22006);
    repeat (4) @(posedge clk); highs(16);
    rd(8'h27, d); highs(16);
    rd(8'h26, d); `CHK(d, 8'h04)
    repeat (4) @(posedge clk); highs(0);
    wr(8'h21, 8'h00); wr(8'h05, 8'h01); repeat (2) @(posedge clk);
    `CHK(ampShutdown, 1'b0)
    $display("detector two test done");
    // detector one on the pdm clock with the serial clock stopped, detector two on
    // the running converter clock, single-pulse indication
    wr(8'h24, 8'h00); wr(8'h22, 8'h00);
    pdmRun <= 1'b1;
    wr(8'h21, 8'h13);
    repeat (12000) @(posedge clk);
    `CHK(ampShutdown, 1'b0)
    pdmRun <= 1'b0;
    waitLoss(10995, 11006);
    highs(4);
    rd(8'h26, d); `CHK(d, 8'h20)
    wr(8'h21, 8'h00); wr(8'h05, 8'h01); repeat (2) @(posedge clk);
    `CHK(ampShutdown, 1'b0)
    $display("source select test done");
    finish_test;
  end
endmodule
